//--- hdl/dual_uart_defines.vh
`ifndef DUAL_UART_DEFINES_VH
`define DUAL_UART_DEFINES_VH

// ***************************************************************
// register map, byte offsets inside one channel window
// ***************************************************************
`define UART_OFS_DATA     5'h00
`define UART_OFS_STATUS   5'h04
`define UART_OFS_CTRL     5'h08
`define UART_OFS_BAUD     5'h0c
`define UART_OFS_INT_STAT 5'h10
`define UART_OFS_INT_EN   5'h14
`define UART_OFS_INT_CLR  5'h18

// ***************************************************************
// control register fields
// ***************************************************************
`define CTL_WLEN      0
`define CTL_STOP2     2
`define CTL_PAR_EN    3
`define CTL_PAR_EVEN  4
`define CTL_PAR_STICK 5
`define CTL_BREAK     6
`define CTL_FIFO_EN   7
`define CTL_FLOW_EN   8
`define CTL_TX_LVL    9
`define CTL_RX_LVL    12

// ***************************************************************
// interrupt status bits
// ***************************************************************
`define INT_RX_LVL 0
`define INT_TX_LVL 1
`define INT_EOT    2
`define INT_PERR   3
`define INT_FERR   4
`define INT_BRK    5
`define INT_OVR    6
`define INT_W      7

// ***************************************************************
// reset values and timing counts
// ***************************************************************
`define RST_CTRL      16'h0083
`define RST_BAUD      16'h0035
`define RST_INT_EN    7'h00
`define FIFO_DEPTH    5'h10
`define OVS_LAST      4'hf
`define OVS_MID       4'h7

`endif

//--- hdl/dual_uart.v
// The register offsets and the Wishbone slave port were left to the implementer.
`include "dual_uart_defines.vh"

// ***************************************************************
// one serial channel with its own registers and fifos
// ***************************************************************
module uart_chan (
   input  wire        i_clk,
   input  wire        i_rst,
   input  wire        i_wr,
   input  wire        i_rd,
   input  wire [4:0]  i_adr,
   input  wire [31:0] i_wdat,
   output reg  [31:0] o_rdat,
   input  wire        i_rxd,
   input  wire        i_cts_n,
   output reg         o_txd,
   output reg         o_rts_n,
   output reg         o_irq,
   output reg         o_tx_single,
   output reg         o_tx_burst,
   output reg         o_rx_single,
   output reg         o_rx_burst
);
   localparam TS_IDLE  = 3'd0;
   localparam TS_START = 3'd1;
   localparam TS_DATA  = 3'd2;
   localparam TS_PAR   = 3'd3;
   localparam TS_STOP  = 3'd4;
   localparam RS_IDLE  = 3'd0;
   localparam RS_START = 3'd1;
   localparam RS_DATA  = 3'd2;
   localparam RS_PAR   = 3'd3;
   localparam RS_STOP  = 3'd4;
   localparam RS_WAIT  = 3'd5;

   reg  [15:0]       ctrl;
   reg  [15:0]       baud;
   reg  [15:0]       bcnt;
   reg  [`INT_W-1:0] int_en;
   reg  [`INT_W-1:0] int_st;
   reg  [7:0]        tx_mem [0:15];
   reg  [10:0]       rx_mem [0:15];
   reg  [3:0]        tx_wp, tx_rp, rx_wp, rx_rp;
   reg  [4:0]        tx_cnt, rx_cnt;
   reg  [1:0]        rxd_sy, cts_sy;
   reg  [2:0]        ts, rs;
   reg  [3:0]        ttk, rtk;
   reg  [2:0]        tbit, rbit;
   reg  [7:0]        tsh, rsh;
   reg               tpar, rpar, tline;
   reg  [4:0]        thr_tx, thr_rx;
   reg               ev_perr, ev_ferr, ev_brk, ev_ovr, ev_eot;

   wire [1:0] wlen    = ctrl[`CTL_WLEN+1:`CTL_WLEN];
   wire       par_en  = ctrl[`CTL_PAR_EN];
   wire       fifo_en = ctrl[`CTL_FIFO_EN];
   wire       flow_en = ctrl[`CTL_FLOW_EN];
   wire [2:0] last    = {1'b0, wlen} + 3'd4;
   wire [4:0] depth   = fifo_en ? `FIFO_DEPTH : 5'h01;
   wire       tick    = (bcnt == 16'h0000);
   wire       rx_s    = rxd_sy[1];
   wire       cts_ok  = ~flow_en | ~cts_sy[1];
   wire       tx_push = i_wr & (i_adr == `UART_OFS_DATA) & (tx_cnt < depth);
   wire       rx_pop  = i_rd & (i_adr == `UART_OFS_DATA) & (rx_cnt != 5'h00);
   wire       tx_pop  = (ts == TS_IDLE) & (tx_cnt != 5'h00) & cts_ok & ~ctrl[`CTL_BREAK];
   wire       rx_push = (rs == RS_STOP) & tick & (rtk == `OVS_LAST) & (rx_cnt < depth);
   wire       rxb_c   = rx_cnt >= thr_rx;
   wire       txb_c   = (depth - tx_cnt) >= thr_tx;
   wire [`INT_W-1:0] ev = {ev_ovr, ev_brk, ev_ferr, ev_perr, ev_eot,
                           txb_c & ~o_tx_burst, rxb_c & ~o_rx_burst};

   function parbit;
      input [7:0] d;
      input [1:0] wl;
      input       even;
      input       stick;
      reg   [7:0] m;
      begin
         m = 8'hff >> (2'd3 - wl);
         parbit = stick ? ~even : ((^(d & m)) ^ ~even);
      end
   endfunction

   function [4:0] level;
      input [2:0] sel;
      input       fen;
      begin
         case (sel)
            3'd0:    level = 5'h02;
            3'd1:    level = 5'h04;
            3'd2:    level = 5'h08;
            3'd3:    level = 5'h0c;
            default: level = 5'h0e;
         endcase
         if (!fen) begin
            level = 5'h01;
         end
      end
   endfunction

   // receive flags of the character just framed, stored beside its data
   wire ev_ferr_n = ~rx_s;
   wire ev_perr_n = par_en & (rpar != parbit(rsh, wlen, ctrl[`CTL_PAR_EVEN],
                                             ctrl[`CTL_PAR_STICK]));
   wire ev_brk_n  = (rsh == 8'h00) & ~rx_s & ~(par_en & rpar);

   always @* begin
      thr_tx = level(ctrl[`CTL_TX_LVL+2:`CTL_TX_LVL], fifo_en);
      thr_rx = level(ctrl[`CTL_RX_LVL+2:`CTL_RX_LVL], fifo_en);
      case (i_adr)
         `UART_OFS_DATA:     o_rdat = {21'h000000, rx_mem[rx_rp]};
         `UART_OFS_STATUS:   o_rdat = {11'h000, rx_cnt, 3'h0, tx_cnt, 3'h0,
                                       ts != TS_IDLE, rx_cnt >= depth, rx_cnt == 5'h00,
                                       tx_cnt >= depth, tx_cnt == 5'h00};
         `UART_OFS_CTRL:     o_rdat = {16'h0000, ctrl};
         `UART_OFS_BAUD:     o_rdat = {16'h0000, baud};
         `UART_OFS_INT_STAT: o_rdat = {25'h0000000, int_st};
         `UART_OFS_INT_EN:   o_rdat = {25'h0000000, int_en};
         default:            o_rdat = 32'h00000000;
      endcase
   end

   // ***************************************************************
   // registers, fifo bookkeeping, interrupts and request lines
   // ***************************************************************
   always @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         ctrl        <= `RST_CTRL;
         baud        <= `RST_BAUD;
         bcnt        <= 16'h0000;
         int_en      <= `RST_INT_EN;
         int_st      <= 7'h00;
         tx_wp       <= 4'h0;
         tx_rp       <= 4'h0;
         rx_wp       <= 4'h0;
         rx_rp       <= 4'h0;
         tx_cnt      <= 5'h00;
         rx_cnt      <= 5'h00;
         rxd_sy      <= 2'b11;
         cts_sy      <= 2'b11;
         o_irq       <= 1'b0;
         o_rts_n     <= 1'b1;
         o_tx_single <= 1'b0;
         o_tx_burst  <= 1'b0;
         o_rx_single <= 1'b0;
         o_rx_burst  <= 1'b0;
      end else begin
         rxd_sy <= {rxd_sy[0], i_rxd};
         cts_sy <= {cts_sy[0], i_cts_n};
         bcnt   <= tick ? baud : bcnt - 16'h0001;
         if (i_wr && i_adr == `UART_OFS_CTRL) begin
            ctrl <= i_wdat[15:0];
         end
         if (i_wr && i_adr == `UART_OFS_BAUD) begin
            baud <= i_wdat[15:0];
         end
         if (i_wr && i_adr == `UART_OFS_INT_EN) begin
            int_en <= i_wdat[`INT_W-1:0];
         end
         // a new event wins over a clear in the same cycle
         if (i_wr && i_adr == `UART_OFS_INT_CLR) begin
            int_st <= (int_st & ~i_wdat[`INT_W-1:0]) | ev;
         end else begin
            int_st <= int_st | ev;
         end
         if (tx_push) begin
            tx_mem[tx_wp] <= i_wdat[7:0];
            tx_wp         <= tx_wp + 4'h1;
         end
         if (tx_pop) begin
            tx_rp <= tx_rp + 4'h1;
         end
         tx_cnt <= tx_cnt + {4'h0, tx_push} - {4'h0, tx_pop};
         if (rx_push) begin
            rx_mem[rx_wp] <= {ev_brk_n, ev_perr_n, ev_ferr_n, rsh};
            rx_wp         <= rx_wp + 4'h1;
         end
         if (rx_pop) begin
            rx_rp <= rx_rp + 4'h1;
         end
         rx_cnt      <= rx_cnt + {4'h0, rx_push} - {4'h0, rx_pop};
         o_irq       <= |(int_st & int_en);
         o_rts_n     <= flow_en & (rx_cnt >= depth);
         o_rx_single <= rx_cnt != 5'h00;
         o_rx_burst  <= rxb_c;
         o_tx_single <= tx_cnt < depth;
         o_tx_burst  <= txb_c;
      end
   end

   // ***************************************************************
   // transmitter
   // ***************************************************************
   always @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         ts     <= TS_IDLE;
         ttk    <= 4'h0;
         tbit   <= 3'd0;
         tsh    <= 8'h00;
         tpar   <= 1'b0;
         tline  <= 1'b1;
         o_txd  <= 1'b1;
         ev_eot <= 1'b0;
      end else begin
         ev_eot <= 1'b0;
         o_txd  <= tline & ~ctrl[`CTL_BREAK];
         if (tick) begin
            ttk <= ttk + 4'h1;
         end
         case (ts)
            TS_IDLE: begin
               if (tx_pop) begin
                  tsh   <= tx_mem[tx_rp];
                  tpar  <= parbit(tx_mem[tx_rp], wlen, ctrl[`CTL_PAR_EVEN],
                                  ctrl[`CTL_PAR_STICK]);
                  ttk   <= 4'h0;
                  tline <= 1'b0;
                  ts    <= TS_START;
               end
            end
            TS_START: begin
               if (tick && ttk == `OVS_LAST) begin
                  tbit  <= 3'd0;
                  tline <= tsh[0];
                  ts    <= TS_DATA;
               end
            end
            TS_DATA: begin
               if (tick && ttk == `OVS_LAST) begin
                  if (tbit == last) begin
                     tbit  <= 3'd0;
                     tline <= par_en ? tpar : 1'b1;
                     ts    <= par_en ? TS_PAR : TS_STOP;
                  end else begin
                     tsh   <= tsh >> 1;
                     tbit  <= tbit + 3'd1;
                     tline <= tsh[1];
                  end
               end
            end
            TS_PAR: begin
               if (tick && ttk == `OVS_LAST) begin
                  tline <= 1'b1;
                  ts    <= TS_STOP;
               end
            end
            TS_STOP: begin
               if (tick && ttk == `OVS_LAST) begin
                  if (ctrl[`CTL_STOP2] && tbit == 3'd0) begin
                     tbit <= 3'd1;
                  end else begin
                     ev_eot <= tx_cnt == 5'h00;
                     ts     <= TS_IDLE;
                  end
               end
            end
            default: ts <= TS_IDLE;
         endcase
      end
   end

   // ***************************************************************
   // receiver: sixteen ticks per bit, sampled at mid bit
   // ***************************************************************
   always @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         rs      <= RS_IDLE;
         rtk     <= 4'h0;
         rbit    <= 3'd0;
         rsh     <= 8'h00;
         rpar    <= 1'b0;
         ev_perr <= 1'b0;
         ev_ferr <= 1'b0;
         ev_brk  <= 1'b0;
         ev_ovr  <= 1'b0;
      end else begin
         ev_perr <= 1'b0;
         ev_ferr <= 1'b0;
         ev_brk  <= 1'b0;
         ev_ovr  <= 1'b0;
         if (tick) begin
            rtk <= rtk + 4'h1;
         end
         case (rs)
            RS_IDLE: begin
               if (!rx_s) begin
                  rtk <= 4'h0;
                  rs  <= RS_START;
               end
            end
            RS_START: begin
               // a low shorter than half a bit is taken as a glitch
               if (tick && rtk == `OVS_MID) begin
                  rtk  <= 4'h0;
                  rbit <= 3'd0;
                  rsh  <= 8'h00;
                  rs   <= rx_s ? RS_IDLE : RS_DATA;
               end
            end
            RS_DATA: begin
               if (tick && rtk == `OVS_LAST) begin
                  rsh[rbit] <= rx_s;
                  rbit      <= rbit + 3'd1;
                  if (rbit == last) begin
                     rs <= par_en ? RS_PAR : RS_STOP;
                  end
               end
            end
            RS_PAR: begin
               if (tick && rtk == `OVS_LAST) begin
                  rpar <= rx_s;
                  rs   <= RS_STOP;
               end
            end
            RS_STOP: begin
               if (tick && rtk == `OVS_LAST) begin
                  ev_ferr <= ev_ferr_n;
                  ev_perr <= ev_perr_n;
                  ev_brk  <= ev_brk_n;
                  ev_ovr  <= rx_cnt >= depth;
                  rs      <= rx_s ? RS_IDLE : RS_WAIT;
               end
            end
            RS_WAIT: begin
               // hold off during a break until the line idles again
               if (rx_s) begin
                  rs <= RS_IDLE;
               end
            end
            default: rs <= RS_IDLE;
         endcase
      end
   end
endmodule

module dual_uart (
   input  wire        I_CLK_SYS,
   input  wire        I_RESET,
   input  wire        I_WB_CYC,
   input  wire        I_WB_STB,
   input  wire        I_WB_WE,
   input  wire [7:0]  I_WB_ADR,
   input  wire [3:0]  I_WB_SEL,
   input  wire [31:0] I_WB_DAT,
   output reg  [31:0] O_WB_DAT,
   output reg         O_WB_ACK,
   input  wire [1:0]  I_RXD,
   input  wire [1:0]  I_CTS_N,
   output wire [1:0]  O_TXD,
   output wire [1:0]  O_RTS_N,
   output wire [1:0]  O_IRQ,
   output wire [1:0]  O_DMA_TX_SINGLE,
   output wire [1:0]  O_DMA_TX_BURST,
   output wire [1:0]  O_DMA_RX_SINGLE,
   output wire [1:0]  O_DMA_RX_BURST
);
   wire        req = I_WB_CYC & I_WB_STB & ~O_WB_ACK;
   wire        hit = I_WB_ADR[7:6] == 2'b00;
   wire [31:0] rd_d [0:1];

   genvar i;
   generate
      for (i = 0; i < 2; i = i + 1) begin : g_chan
         wire sel = req & hit & (I_WB_ADR[5] == (i == 1));
         uart_chan u_chan (
            .i_clk       (I_CLK_SYS),
            .i_rst       (I_RESET),
            .i_wr        (sel & I_WB_WE & I_WB_SEL[0]),
            .i_rd        (sel & ~I_WB_WE),
            .i_adr       (I_WB_ADR[4:0]),
            .i_wdat      (I_WB_DAT),
            .o_rdat      (rd_d[i]),
            .i_rxd       (I_RXD[i]),
            .i_cts_n     (I_CTS_N[i]),
            .o_txd       (O_TXD[i]),
            .o_rts_n     (O_RTS_N[i]),
            .o_irq       (O_IRQ[i]),
            .o_tx_single (O_DMA_TX_SINGLE[i]),
            .o_tx_burst  (O_DMA_TX_BURST[i]),
            .o_rx_single (O_DMA_RX_SINGLE[i]),
            .o_rx_burst  (O_DMA_RX_BURST[i])
         );
      end
   endgenerate

   // ***************************************************************
   // wishbone slave: one wait state, unmapped reads give zero
   // ***************************************************************
   always @(posedge I_CLK_SYS or posedge I_RESET) begin
      if (I_RESET) begin
         O_WB_ACK <= 1'b0;
         O_WB_DAT <= 32'h00000000;
      end else begin
         O_WB_ACK <= req;
         if (req && !I_WB_WE) begin
            O_WB_DAT <= hit ? rd_d[I_WB_ADR[5]] : 32'h00000000;
         end
      end
   end
endmodule

//--- testbench/dual_uart_properties.sv
module dual_uart_properties (
   input wire        I_CLK_SYS,
   input wire        I_RESET,
   input wire        I_WB_CYC,
   input wire        I_WB_STB,
   input wire        I_WB_WE,
   input wire [7:0]  I_WB_ADR,
   input wire [31:0] O_WB_DAT,
   input wire        O_WB_ACK,
   input wire [1:0]  O_TXD,
   input wire [1:0]  O_RTS_N,
   input wire [1:0]  O_DMA_TX_SINGLE,
   input wire [1:0]  O_DMA_TX_BURST,
   input wire [1:0]  O_DMA_RX_SINGLE,
   input wire [1:0]  O_DMA_RX_BURST
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge I_CLK_SYS); endclocking
   default disable iff (I_RESET);

   // ***************************************************************
   // bus sequences and the bus, line and request-line checks
   // ***************************************************************
   sequence bus_req;
      I_WB_CYC && I_WB_STB && !O_WB_ACK;
   endsequence
   sequence bad_read;
      bus_req ##0 (!I_WB_WE && I_WB_ADR[7:6] != 2'h0);
   endsequence

   ack_answer_a : assert property (bus_req |=> O_WB_ACK)
      else $error("ack missing one cycle after request");
   ack_pulse_a : assert property (O_WB_ACK |=> !O_WB_ACK)
      else $error("ack longer than one cycle");
   unmapped_read_a : assert property (bad_read |=> O_WB_DAT == 32'h0)
      else $error("unmapped read not zero");
   start_hold_a : assert property ($fell(O_TXD[0]) |-> !O_TXD[0] [*8])
      else $error("start bit too short");
   bit_hold_a : assert property ($changed(O_TXD[1]) |=> $stable(O_TXD[1]) [*7])
      else $error("line bit too short");
   tx_burst_a : assert property ((O_DMA_TX_BURST & ~O_DMA_TX_SINGLE) == 2'h0)
      else $error("tx burst without single");
   rx_burst_a : assert property ((O_DMA_RX_BURST & ~O_DMA_RX_SINGLE) == 2'h0)
      else $error("rx burst without single");
   rts_full_a : assert property ($rose(O_RTS_N[1]) |-> O_DMA_RX_BURST[1])
      else $error("rts dropped with room left");
endmodule

bind dual_uart dual_uart_properties i_dual_uart_properties (
   .I_CLK_SYS(I_CLK_SYS), .I_RESET(I_RESET), .I_WB_CYC(I_WB_CYC),
   .I_WB_STB(I_WB_STB), .I_WB_WE(I_WB_WE), .I_WB_ADR(I_WB_ADR),
   .O_WB_DAT(O_WB_DAT), .O_WB_ACK(O_WB_ACK), .O_TXD(O_TXD), .O_RTS_N(O_RTS_N),
   .O_DMA_TX_SINGLE(O_DMA_TX_SINGLE), .O_DMA_TX_BURST(O_DMA_TX_BURST),
   .O_DMA_RX_SINGLE(O_DMA_RX_SINGLE), .O_DMA_RX_BURST(O_DMA_RX_BURST));

//--- testbench/uart_remote.sv
module uart_remote #(parameter int BIT = 32) (
   input  logic       i_clk,
   input  logic       i_txd,
   input  logic       i_hold,
   output logic       o_rxd,
   output logic       o_cts_n,
   output logic [7:0] o_got,
   output logic       o_got_stb
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      o_rxd = 1'b1;
      o_got = 8'h00;
      o_got_stb = 1'b0;
   end
   // a held remote stalls the sender only when flow control is on
   assign o_cts_n = i_hold;

   task automatic send(input logic [7:0] d);
      for (int k = 0; k < 10; k++) begin
         o_rxd <= (k == 0) ? 1'b0 : (k == 9) ? 1'b1 : d[k-1];
         repeat (BIT) @(posedge i_clk);
      end
   endtask

   task automatic brk;
      o_rxd <= 1'b0;
      repeat (12 * BIT) @(posedge i_clk);
      o_rxd <= 1'b1;
      repeat (2 * BIT) @(posedge i_clk);
   endtask

   // sample mid bit; a low stop yields no byte, so a bad frame leaves its byte queued in tq for the bench to flag
   always begin
      @(negedge i_txd);
      repeat (BIT / 2) @(posedge i_clk);
      if (!i_txd) begin
         for (int k = 0; k < 8; k++) begin
            repeat (BIT) @(posedge i_clk);
            o_got[k] <= i_txd;
         end
         repeat (BIT) @(posedge i_clk);
         o_got_stb <= i_txd;
         @(posedge i_clk);
         o_got_stb <= 1'b0;
      end
   end
endmodule

//--- testbench/tb_dual_uart.sv
module tb_dual_uart;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [31:0] ALL = 32'hffff_ffff;
   logic        clk = 1'b0;
   logic        rst = 1'b1;
   logic        cyc = 1'b0;
   logic        stb = 1'b0;
   logic        we = 1'b0;
   logic [7:0]  adr = 8'h00;
   logic [31:0] wdat = 32'h0;
   logic        hold = 1'b0;
   logic [31:0] rdat;
   logic        ack, rem_rxd, rem_cts_n, got_stb;
   logic [1:0]  txd, rts_n, irq, txs, txb, rxs, rxb;
   logic [7:0]  got, d, m, c;
   logic [63:0] e;
   logic [63:0] rq[$];
   logic [7:0]  tq[$];
   int          bad_count = 0;
   int          samples_checked = 0;
   int          n;
   int          lv[5] = '{2, 4, 8, 12, 14};

   always #5 clk = ~clk;

   dual_uart i_dual_uart (.I_CLK_SYS(clk), .I_RESET(rst), .I_WB_CYC(cyc), .I_WB_STB(stb),
      .I_WB_WE(we), .I_WB_ADR(adr), .I_WB_SEL(4'hf), .I_WB_DAT(wdat), .O_WB_DAT(rdat),
      .O_WB_ACK(ack), .I_RXD({txd[1], rem_rxd}), .I_CTS_N({rts_n[1], rem_cts_n}),
      .O_TXD(txd), .O_RTS_N(rts_n), .O_IRQ(irq), .O_DMA_TX_SINGLE(txs),
      .O_DMA_TX_BURST(txb), .O_DMA_RX_SINGLE(rxs), .O_DMA_RX_BURST(rxb));
   uart_remote #(.BIT(32)) i_uart_remote (.i_clk(clk), .i_txd(txd[0]), .i_hold(hold),
      .o_rxd(rem_rxd), .o_cts_n(rem_cts_n), .o_got(got), .o_got_stb(got_stb));

   // ***************************************************************
   // reporting
   // ***************************************************************
   task automatic chk(input logic ok, input string s);
      samples_checked++;
      if (!ok) begin
         bad_count++;
         $display("unexpected at %0t: %s", $time, s);
      end
   endtask

   task automatic close_out;
      $display("checks %0d mismatches %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   task automatic tmo(input int lim);
      if (n >= lim) begin
         bad_count++;
         $display("unexpected at %0t: wait ran out", $time);
         close_out();
      end
   endtask

   // reads note the expected word with its mask; the watcher compares at ack
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] v,
                     input logic [31:0] msk);
      if (!w)
         rq.push_back({msk, v & msk});
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= v;
      for (n = 0; n < 50 && ack !== 1'b1; n++) @(posedge clk);
      tmo(50);
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
      @(posedge clk);
   endtask

   task automatic push0(input logic [7:0] b);
      tq.push_back(b);
      wb(1, 8'h00, {24'h0, b}, 0);
   endtask

   always @(posedge clk) begin
      if (ack === 1'b1 && rq.size() > 0) begin
         e = rq.pop_front();
         chk((rdat & e[63:32]) === e[31:0], "read word");
      end
      if (got_stb === 1'b1) begin
         e = (tq.size() > 0) ? {56'h0, tq.pop_front()} : 64'h1ff;
         chk(got === e[7:0] && e[8] === 1'b0, "line byte");
      end
   end

   // ***************************************************************
   // scenarios
   // ***************************************************************
   initial begin
      void'($urandom(32'h361a4646));
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      wb(0, 8'h08, 32'h83, ALL);
      wb(0, 8'h0c, 32'h35, ALL);
      wb(0, 8'h04, 32'h5, 32'h1f1f1f);
      wb(0, 8'h10, 32'h2, ALL);
      wb(1, 8'h40, ALL, 0);
      wb(0, 8'h40, 32'h0, ALL);
      wb(0, 8'h1c, 32'h0, ALL);
      wb(1, 8'h0c, 32'h1, 0);
      wb(1, 8'h2c, 32'h0, 0);
      // a new divisor only loads at the next tick of the old one
      repeat (64) @(posedge clk);
      d = 8'($urandom);
      i_uart_remote.send(d);
      for (n = 0; n < 400 && rxs[0] !== 1'b1; n++) @(posedge clk);
      tmo(400);
      wb(0, 8'h00, {24'h0, d}, 32'h7ff);
      i_uart_remote.brk();
      wb(0, 8'h10, 32'h20, 32'h20);
      hold <= 1'b1;
      wb(1, 8'h08, 32'h103, 0);
      push0(8'($urandom));
      for (n = 0; n < 200 && txd[0] === 1'b1; n++) @(posedge clk);
      chk(n == 200 && txs[0] === 1'b0, "sent while held");
      chk(rts_n[0] === 1'b1, "rts with full fifo");
      wb(0, 8'h04, 32'h2, 32'h2);
      hold <= 1'b0;
      for (n = 0; n < 2000 && tq.size() > 0; n++) @(posedge clk);
      tmo(2000);
      wb(1, 8'h08, 32'h83, 0);
      wb(1, 8'h18, 32'h7f, 0);
      wb(1, 8'h14, 32'h4, 0);
      push0(8'($urandom));
      push0(8'($urandom));
      for (n = 0; n < 2000 && irq[0] !== 1'b1; n++) @(posedge clk);
      tmo(2000);
      chk(tq.size() == 0, "end event early");
      wb(0, 8'h10, 32'h4, 32'h4);
      wb(1, 8'h14, 32'h0, 0);
      chk(irq[0] === 1'b0, "masked irq");
      wb(1, 8'h14, 32'h4, 0);
      chk(irq[0] === 1'b1, "sticky irq");
      wb(1, 8'h18, 32'h4, 0);
      chk(irq[0] === 1'b0, "cleared irq");
      wb(1, 8'h08, 32'hc3, 0);
      for (n = 0; n < 400 && txd[0] === 1'b0; n++) @(posedge clk);
      chk(n == 400, "break level");
      wb(1, 8'h08, 32'h83, 0);
      for (int k = 0; k < 16; k++) begin
         c = {k[3] & k[2], k[2], 1'(k >= 4), 1'($urandom), k[1:0]};
         d = 8'($urandom);
         m = 8'hff >> (2'h3 - c[1:0]);
         wb(1, 8'h28, {24'h0, 2'b10, c[5:0]}, 0);
         wb(1, 8'h20, {24'h0, d}, 0);
         for (n = 0; n < 1000 && rxs[1] !== 1'b1; n++) @(posedge clk);
         tmo(1000);
         wb(0, 8'h20, {24'h0, d & m}, 32'h7ff);
      end
      foreach (lv[j]) begin
         wb(1, 8'h28, 32'h183 | (32'(j) << 12), 0);
         for (int k = 0; k < 16; k++) wb(1, 8'h20, 32'(k), 0);
         for (n = 0; n < 4000 && rxb[1] !== 1'b1; n++) @(posedge clk);
         tmo(4000);
         wb(0, 8'h24, 32'(lv[j]) << 16, 32'h1f0000);
         for (n = 0; n < 4000 && rts_n[1] !== 1'b1; n++) @(posedge clk);
         tmo(4000);
         for (int k = 0; k < 16; k++) wb(0, 8'h20, 32'(k), 32'h7ff);
      end
      close_out();
   end
endmodule
